// File: shared/int_ctrl_defines.vh
`ifndef INT_CTRL_DEFINES_VH
`define INT_CTRL_DEFINES_VH

// Bus geometry
`define AXI_AW          8
`define AXI_DW          32
`define REG_IDX_LSB     2
`define REG_IDX_MSB     3
`define REG_HI_LSB      4
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

// Register indices, address bits 3:2 (byte offset divided by four)
`define OFS_USB_TOKEN   2'h0
`define OFS_LVD_SER_MF  2'h1
`define OFS_TIMER_MATCH 2'h2
`define OFS_GLOBAL      2'h3

// Field layout inside each 8-bit control register
`define FLD_EN_LSB      0
`define FLD_FLAG_LSB    4
`define FLD_GIE         0
`define REG_RESET       8'h00

// Source numbering, index 0 is served first
`define NUM_SRC         6
`define NUM_FLAG        10
`define NUM_TM          4
`define SRC_SETUP       0
`define SRC_IN          1
`define SRC_OUT         2
`define SRC_MF          3
`define SRC_SERIAL      4
`define SRC_LVD         5
`define FLAG_TM_LSB     6

// Program counter and vector addresses
`define PC_W            13
`define VEC_SETUP       13'h0004
`define VEC_IN          13'h0008
`define VEC_OUT         13'h000c
`define VEC_MF          13'h0010
`define VEC_SERIAL      13'h0014
`define VEC_LVD         13'h0018

`endif

// File: hdl/flag_cell.v
`timescale 1ns/1ns
`include "int_ctrl_defines.vh"

// One request flag: event set beats any clear in the same cycle
module flag_cell (
    // Clock and reset
    input  wire sys_clk,
    input  wire rst_n,
    // Set and clear sources
    input  wire hw_set,
    input  wire sw_wr,
    input  wire sw_val,
    input  wire auto_clr,
    // Flag state
    output reg  flag_r
);

    reg flag_nxt;

    // Next value of the flag
    always @* begin
        flag_nxt = flag_r & ~auto_clr;
        if (sw_wr) begin
            flag_nxt = sw_val;
        end
        if (hw_set) begin
            flag_nxt = 1'b1;
        end
    end

    // Flag storage
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

endmodule

// File: hdl/int_ctrl.v
// Function
// - Events set their flag regardless of enable
// - Vector only when source enable is one
// - Global enable zero blocks all vectoring
// - Push next instruction address on accept
// - Then load program counter with vector
// - Return instruction pops saved program counter
// - Dedicated vectors, timers share one vector
// - Entering service clears global enable
// - Flags keep setting while service blocks
// - No accept while return stack full
// - Fixed priority among simultaneous requests
// - Any flag becoming set wakes device
// - Second register flags at bits 6,5,4
// - Second register enables at bits 2,1,0
// - Endpoint 0 tokens set their flags
// - Timer flag rising sets grouped flag
// - Service clears own flag and global enable
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
`include "int_ctrl_defines.vh"

module int_ctrl (
    // Clock and reset
    input  wire                   sys_clk,
    input  wire                   rst_n,
    // Event pulses from on-chip logic
    input  wire                   ev_setup_token,
    input  wire                   ev_in_token,
    input  wire                   ev_out_token,
    input  wire                   ev_low_voltage,
    input  wire                   ev_serial_byte,
    input  wire                   ev_t0_cmp_p,
    input  wire                   ev_t0_cmp_a,
    input  wire                   ev_t1_cmp_p,
    input  wire                   ev_t1_cmp_a,
    // Core sequencer side
    input  wire                   core_ready,
    input  wire [`PC_W-1:0]       pc_next,
    input  wire                   stack_full,
    input  wire                   return_from_interrupt_exec,
    output reg                    push_valid_r,
    output reg  [`PC_W-1:0]       push_pc_r,
    output reg                    vec_valid_r,
    output reg  [`PC_W-1:0]       vec_addr_r,
    output reg                    pop_r,
    output reg                    wake_r,
    // AXI4-Lite write channels
    input  wire [`AXI_AW-1:0]     s_axi_awaddr,
    input  wire                   s_axi_awvalid,
    output reg                    s_axi_awready,
    input  wire [`AXI_DW-1:0]     s_axi_wdata,
    input  wire [`AXI_DW/8-1:0]   s_axi_wstrb,
    input  wire                   s_axi_wvalid,
    output reg                    s_axi_wready,
    output reg  [1:0]             s_axi_bresp,
    output reg                    s_axi_bvalid,
    input  wire                   s_axi_bready,
    // AXI4-Lite read channels
    input  wire [`AXI_AW-1:0]     s_axi_araddr,
    input  wire                   s_axi_arvalid,
    output reg                    s_axi_arready,
    output reg  [`AXI_DW-1:0]     s_axi_rdata,
    output reg  [1:0]             s_axi_rresp,
    output reg                    s_axi_rvalid,
    input  wire                   s_axi_rready
);

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_PUSH = 3'b010;
    localparam [2:0] ST_LOAD = 3'b100;

    reg  [2:0]              state_r;
    reg  [2:0]              state_nxt;
    reg                     gie_r;
    reg  [2:0]              usb_en_r;
    reg  [2:0]              misc_en_r;
    reg  [`NUM_TM-1:0]      tm_en_r;
    reg  [`NUM_FLAG-1:0]    flag_prev_r;
    reg  [`AXI_AW-1:0]      wr_addr_r;
    reg  [7:0]              wr_data_r;
    reg                     wr_lane_r;
    reg  [`PC_W-1:0]        vec_sel;
    reg  [`NUM_SRC-1:0]     grant;
    reg  [`NUM_FLAG-1:0]    sw_wr;
    reg  [`NUM_FLAG-1:0]    sw_val;
    reg  [7:0]              rd_byte;
    wire [`NUM_FLAG-1:0]    flag;
    wire [`NUM_FLAG-1:0]    hw_set;
    wire [`NUM_FLAG-1:0]    auto_clr;
    wire [`NUM_SRC-1:0]     src_en;
    wire [`NUM_SRC-1:0]     cand;
    wire [`NUM_TM-1:0]      tm_flag;
    wire                    mf_set;
    wire                    accept;
    wire                    do_write;
    wire                    wr_mapped;
    wire [1:0]              wr_idx;
    wire                    wr_ok;
    wire                    rd_mapped;
    integer                 i;

    // Timer match flags and their grouped request
    assign tm_flag = flag[`FLAG_TM_LSB +: `NUM_TM];
    assign mf_set  = |(tm_flag & ~flag_prev_r[`FLAG_TM_LSB +: `NUM_TM]);

    // Hardware set sources, one per flag
    assign hw_set = {ev_t1_cmp_a, ev_t1_cmp_p, ev_t0_cmp_a, ev_t0_cmp_p,
                     ev_low_voltage, ev_serial_byte, mf_set,
                     ev_out_token, ev_in_token, ev_setup_token};

    // Pending sources that may be taken
    assign src_en = {misc_en_r, usb_en_r};
    assign cand   = flag[`NUM_SRC-1:0] & src_en;
    assign accept = (state_r == ST_IDLE) & core_ready & gie_r &
                    (|cand) & ~stack_full;

    // Service clears only the served source, never timer flags
    assign auto_clr = {{`NUM_TM{1'b0}},
                       grant & {`NUM_SRC{accept}}};

    // Fixed priority pick, lowest index first, and its vector
    always @* begin
        grant   = {`NUM_SRC{1'b0}};
        vec_sel = `VEC_SETUP;
        for (i = `NUM_SRC - 1; i >= 0; i = i - 1) begin
            if (cand[i]) begin
                grant = {`NUM_SRC{1'b0}};
                grant[i] = 1'b1;
            end
        end
        case (1'b1)
            grant[`SRC_IN]:     vec_sel = `VEC_IN;
            grant[`SRC_OUT]:    vec_sel = `VEC_OUT;
            grant[`SRC_MF]:     vec_sel = `VEC_MF;
            grant[`SRC_SERIAL]: vec_sel = `VEC_SERIAL;
            grant[`SRC_LVD]:    vec_sel = `VEC_LVD;
            default:            vec_sel = `VEC_SETUP;
        endcase
    end

    // Flag cells
    genvar g;
    generate
        for (g = 0; g < `NUM_FLAG; g = g + 1) begin : gen_flag
            flag_cell u_flag (
                .sys_clk  (sys_clk),
                .rst_n    (rst_n),
                .hw_set   (hw_set[g]),
                .sw_wr    (sw_wr[g]),
                .sw_val   (sw_val[g]),
                .auto_clr (auto_clr[g]),
                .flag_r   (flag[g])
            );
        end
    endgenerate

    // Write decode
    assign do_write  = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    assign wr_mapped = (wr_addr_r[`AXI_AW-1:`REG_HI_LSB] == 4'h0);
    assign wr_idx    = wr_addr_r[`REG_IDX_MSB:`REG_IDX_LSB];
    assign wr_ok     = do_write & wr_mapped & wr_lane_r;
    assign rd_mapped = (s_axi_araddr[`AXI_AW-1:`REG_HI_LSB] == 4'h0);

    // Software writes to flag bits
    always @* begin
        sw_wr  = {`NUM_FLAG{1'b0}};
        sw_val = {`NUM_FLAG{1'b0}};
        sw_val[2:0] = wr_data_r[`FLD_FLAG_LSB +: 3];
        sw_val[5:3] = wr_data_r[`FLD_FLAG_LSB +: 3];
        sw_val[9:6] = wr_data_r[`FLD_FLAG_LSB +: `NUM_TM];
        if (wr_ok) begin
            case (wr_idx)
                `OFS_USB_TOKEN:   sw_wr[2:0] = 3'h7;
                `OFS_LVD_SER_MF:  sw_wr[5:3] = 3'h7;
                `OFS_TIMER_MATCH: sw_wr[9:6] = 4'hf;
                default:          sw_wr = {`NUM_FLAG{1'b0}};
            endcase
        end
    end

    // Enable registers and global enable
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            usb_en_r  <= 3'h0;
            misc_en_r <= 3'h0;
            tm_en_r   <= 4'h0;
            gie_r     <= 1'b0;
        end else begin
            if (wr_ok && wr_idx == `OFS_USB_TOKEN) begin
                usb_en_r <= wr_data_r[`FLD_EN_LSB +: 3];
            end
            if (wr_ok && wr_idx == `OFS_LVD_SER_MF) begin
                misc_en_r <= wr_data_r[`FLD_EN_LSB +: 3];
            end
            if (wr_ok && wr_idx == `OFS_TIMER_MATCH) begin
                tm_en_r <= wr_data_r[`FLD_EN_LSB +: `NUM_TM];
            end
            if (accept) begin
                gie_r <= 1'b0;
            end else if (wr_ok && wr_idx == `OFS_GLOBAL) begin
                gie_r <= wr_data_r[`FLD_GIE];
            end
        end
    end

    // Read value of the addressed register
    always @* begin
        rd_byte = `REG_RESET;
        case (s_axi_araddr[`REG_IDX_MSB:`REG_IDX_LSB])
            `OFS_USB_TOKEN:
                rd_byte = {1'b0, flag[2:0], 1'b0, usb_en_r};
            `OFS_LVD_SER_MF:
                rd_byte = {1'b0, flag[5:3], 1'b0, misc_en_r};
            `OFS_TIMER_MATCH:
                rd_byte = {tm_flag, tm_en_r};
            default:
                rd_byte = {7'h00, gie_r};
        endcase
    end

    // AXI4-Lite write side, address and data in either order
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            wr_addr_r     <= {`AXI_AW{1'b0}};
            wr_data_r     <= 8'h00;
            wr_lane_r     <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wr_addr_r     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wr_data_r    <= s_axi_wdata[7:0];
                wr_lane_r    <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // AXI4-Lite read side
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= {`AXI_DW{1'b0}};
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_mapped ? {24'h000000, rd_byte}
                                           : {`AXI_DW{1'b0}};
                s_axi_rresp   <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Entry sequencer next state
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: if (accept) state_nxt = ST_PUSH;
            ST_PUSH: state_nxt = ST_LOAD;
            ST_LOAD: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    // Push, vector load, pop and wake strobes
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r      <= ST_IDLE;
            push_valid_r <= 1'b0;
            push_pc_r    <= {`PC_W{1'b0}};
            vec_valid_r  <= 1'b0;
            vec_addr_r   <= {`PC_W{1'b0}};
            pop_r        <= 1'b0;
            wake_r       <= 1'b0;
            flag_prev_r  <= {`NUM_FLAG{1'b0}};
        end else begin
            state_r      <= state_nxt;
            push_valid_r <= accept;
            if (accept) begin
                push_pc_r  <= pc_next;
                vec_addr_r <= vec_sel;
            end
            vec_valid_r  <= (state_r == ST_PUSH);
            pop_r        <= return_from_interrupt_exec;
            flag_prev_r  <= flag;
            wake_r       <= |(flag & ~flag_prev_r);
        end
    end

endmodule

// File: sim/int_ctrl_checker.sv
`timescale 1ns/1ns
`include "int_ctrl_defines.vh"

module int_ctrl_checker (
    // Clock and reset
    input wire               sys_clk,
    input wire               rst_n,
    // Core side
    input wire [`PC_W-1:0]   pc_next,
    input wire               stack_full,
    input wire               return_from_interrupt_exec,
    input wire               push_valid_r,
    input wire [`PC_W-1:0]   push_pc_r,
    input wire               vec_valid_r,
    input wire [`PC_W-1:0]   vec_addr_r,
    input wire               pop_r,
    // Read channel
    input wire [`AXI_AW-1:0] s_axi_araddr,
    input wire               s_axi_arvalid,
    input wire               s_axi_arready,
    input wire [`AXI_DW-1:0] s_axi_rdata,
    input wire [1:0]         s_axi_rresp,
    input wire               s_axi_rvalid
);
    // Mapped window is the lowest sixteen bytes
    wire hi_zero = (s_axi_araddr[7:4] == 4'h0);

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    chk_push_vec: assert property (push_valid_r |=> vec_valid_r)
        else $error("no vector load after push");
    chk_push_gap: assert property (push_valid_r |=> !push_valid_r [*2])
        else $error("accept too soon after accept");
    chk_push_pc: assert property (push_valid_r |-> push_pc_r == $past(pc_next))
        else $error("pushed address is not the next address");
    chk_vec_table: assert property (vec_valid_r |-> vec_addr_r inside
        {`VEC_SETUP, `VEC_IN, `VEC_OUT, `VEC_MF, `VEC_SERIAL, `VEC_LVD})
        else $error("vector outside the table");
    chk_pop_follow: assert property (pop_r == $past(return_from_interrupt_exec))
        else $error("pop strobe not one cycle after return");
    chk_full_block: assert property (stack_full |=> !push_valid_r)
        else $error("accept while stack full");
    chk_rd_resp: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && s_axi_rresp ==
        ($past(hi_zero) ? `RESP_OKAY : `RESP_SLVERR))
        else $error("read answer late or wrong code");
    chk_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 0)
        else $error("upper read bits not zero");
endmodule

bind int_ctrl int_ctrl_checker u_chk (
    .sys_clk, .rst_n, .pc_next, .stack_full, .return_from_interrupt_exec, .push_valid_r,
    .push_pc_r, .vec_valid_r, .vec_addr_r, .pop_r, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid
);

// File: sim/core_model.sv
`timescale 1ns/1ns

module core_model #(
    parameter DEPTH = 2
) (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        rst_n,
    // Controller strobes
    input  wire        push_valid,
    input  wire [12:0] push_pc,
    input  wire        vec_valid,
    input  wire [12:0] vec_addr,
    input  wire        pop,
    // Sequencer state
    output wire        core_ready,
    output wire [12:0] pc_next,
    output wire        stack_full,
    output reg  [12:0] pc_r,
    output reg  [12:0] ret_exp_r
);
    reg [12:0] stk_r [0:DEPTH-1];
    reg [12:0] exp_r [0:DEPTH-1];
    reg [12:0] last_r;
    int        sp_r;

    // Every cycle is an instruction boundary
    assign core_ready = 1'b1;
    assign pc_next    = pc_r + 13'h1;
    assign stack_full = (sp_r == DEPTH);

    // Return stack and program counter sequencing
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_r <= 13'h0100;
            sp_r <= 0;
            last_r <= 13'h0;
            ret_exp_r <= 13'h0;
        end else begin
            last_r <= pc_next;
            if (push_valid) begin
                stk_r[sp_r] <= push_pc;
                exp_r[sp_r] <= last_r;
                sp_r <= sp_r + 1;
            end
            if (pop) begin
                pc_r <= stk_r[sp_r-1];
                ret_exp_r <= exp_r[sp_r-1];
                sp_r <= sp_r - 1;
            end else if (vec_valid)
                pc_r <= vec_addr;
            else
                pc_r <= pc_next;
        end
    end
endmodule

// File: sim/tb.sv
`timescale 1ns/1ns
`include "int_ctrl_defines.vh"

module tb;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] w;
        logic [31:0] r;
        logic [1:0]  e;
    } row_t;

    // Stimulus
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [8:0]  ev = 9'h0;
    logic        return_from_interrupt_exec = 1'b0;
    logic [7:0]  awaddr = 8'h0;
    logic [7:0]  araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        arvalid = 1'b0;
    logic [3:0]  strb = 4'hf;
    // Observed
    wire         awready, wready, bvalid, arready, rvalid;
    wire         push_v, vec_v, pop, wake, ready, full;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    wire [12:0]  push_pc, vec_a, pc_next, pc_m, ret_m;
    logic [31:0] rdat;
    logic [1:0]  rsp;
    logic [12:0] vt [6] = '{`VEC_SETUP, `VEC_IN, `VEC_OUT, `VEC_MF,
                            `VEC_SERIAL, `VEC_LVD};
    row_t        rows [11];
    int          nvec = 0;
    int          mismatches = 0;
    int          total_checks = 0;
    int          w;

    always #5 sys_clk = ~sys_clk;

    // Vector strobes seen so far
    always @(posedge sys_clk) if (vec_v === 1'b1) nvec <= nvec + 1;

    int_ctrl uut (
        .sys_clk(sys_clk), .rst_n(rst_n),
        .ev_setup_token(ev[0]), .ev_in_token(ev[1]), .ev_out_token(ev[2]),
        .ev_low_voltage(ev[3]), .ev_serial_byte(ev[4]),
        .ev_t0_cmp_p(ev[5]), .ev_t0_cmp_a(ev[6]),
        .ev_t1_cmp_p(ev[7]), .ev_t1_cmp_a(ev[8]),
        .core_ready(ready), .pc_next(pc_next), .stack_full(full),
        .return_from_interrupt_exec(return_from_interrupt_exec), .push_valid_r(push_v), .push_pc_r(push_pc),
        .vec_valid_r(vec_v), .vec_addr_r(vec_a), .pop_r(pop), .wake_r(wake),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(1'b1)
    );
    core_model u_core (
        .sys_clk(sys_clk), .rst_n(rst_n), .push_valid(push_v),
        .push_pc(push_pc), .vec_valid(vec_v), .vec_addr(vec_a), .pop(pop),
        .core_ready(ready), .pc_next(pc_next), .stack_full(full),
        .pc_r(pc_m), .ret_exp_r(ret_m)
    );

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic guard(input int n);
        if (n >= 64) begin
            mismatches++;
            wrap_up();
        end
    endtask

    task automatic cmp_val(input string nm, input logic [31:0] x,
                           input logic [31:0] g);
        total_checks++;
        if (g !== x) begin
            mismatches++;
            $display("FAIL %s exp %h got %h", nm, x, g);
        end
    endtask

    task automatic cmp_resp(input string nm, input logic [1:0] x);
        total_checks++;
        if (rsp !== x) begin
            mismatches++;
            $display("FAIL %s exp %h got %h", nm, x, rsp);
        end
    endtask

    // Bus write: each channel released at its own handshake
    task automatic wr(input [7:0] a, input [31:0] d);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        rsp = bresp;
        guard(n);
    endtask

    task automatic rd(input [7:0] a);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rdat = rdata;
        rsp = rresp;
        guard(n);
    endtask

    // Allow nesting again, then expect a jump to v
    task automatic serve(input [12:0] v);
        int n;
        wr(8'h0c, 32'h1);
        for (n = 0; n < 64; n++) begin
            @(posedge sys_clk);
            if (vec_v === 1'b1) break;
        end
        guard(n);
        @(posedge sys_clk);
        cmp_val("pc", v, pc_m);
    endtask

    task automatic ret_pulse;
        return_from_interrupt_exec <= 1'b1;
        @(posedge sys_clk);
        return_from_interrupt_exec <= 1'b0;
        repeat (2) @(posedge sys_clk);
        cmp_val("ret pc", ret_m, pc_m);
    endtask

    task automatic quiet(input int k);
        int n0;
        n0 = nvec;
        repeat (12) @(posedge sys_clk);
        cmp_val("vectors", k, nvec - n0);
    endtask

    task automatic pulse(input [8:0] m);
        ev <= m;
        @(posedge sys_clk);
        ev <= 9'h0;
        w = 0;
        repeat (4) begin
            @(posedge sys_clk);
            if (wake === 1'b1) w++;
        end
    endtask

    initial begin
        rows = '{'{8'h0c, 32'hff, 32'h01, 2'b00},
                 '{8'h00, 32'ha9, 32'h21, 2'b00},
                 '{8'h00, 32'h5a, 32'h52, 2'b00},
                 '{8'h04, 32'hffffffa5, 32'h25, 2'b00},
                 '{8'h04, 32'h5a, 32'h52, 2'b00},
                 '{8'h08, 32'ha5, 32'ha5, 2'b00},
                 '{8'h10, 32'hff, 32'h00, 2'b10},
                 '{8'h00, 32'h00, 32'h00, 2'b00},
                 '{8'h04, 32'h00, 32'h00, 2'b00},
                 '{8'h08, 32'h00, 32'h00, 2'b00},
                 '{8'h0c, 32'h00, 32'h00, 2'b00}};
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            cmp_resp("wresp", rows[i].e);
            rd(rows[i].a);
            cmp_resp("rresp", rows[i].e);
            cmp_val("rdata", rows[i].r, rdat);
        end
        // Reset in mid-run clears every register
        wr(8'h08, 32'hff);
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        for (int i = 0; i < 4; i++) begin
            rd(8'(4 * i));
            cmp_val("reset value", 32'h0, rdat);
        end
        // Write with lane 0 off answers OKAY and changes nothing
        strb <= 4'he;
        wr(8'h0c, 32'h1);
        cmp_resp("masked wresp", `RESP_OKAY);
        strb <= 4'hf;
        rd(8'h0c);
        cmp_val("masked write", 32'h0, rdat);
        // Pending flag blocked by its enable, then by global enable
        wr(8'h00, 32'h10);
        wr(8'h0c, 32'h1);
        quiet(0);
        wr(8'h0c, 32'h0);
        wr(8'h00, 32'h11);
        quiet(0);
        rd(8'h00);
        cmp_val("held flag", 32'h11, rdat);
        serve(`VEC_SETUP);
        rd(8'h0c);
        cmp_val("global", 32'h0, rdat);
        rd(8'h00);
        cmp_val("own flag", 32'h01, rdat);
        ret_pulse();
        // All six pending, served in fixed order
        wr(8'h00, 32'h77);
        wr(8'h04, 32'h77);
        foreach (vt[i]) begin
            serve(vt[i]);
            ret_pulse();
        end
        rd(8'h04);
        cmp_val("served flags", 32'h07, rdat);
        // Full return stack holds a request off until a pop
        repeat (2) begin
            wr(8'h00, 32'h11);
            serve(`VEC_SETUP);
        end
        wr(8'h00, 32'h11);
        wr(8'h0c, 32'h1);
        quiet(0);
        ret_pulse();
        quiet(1);
        repeat (2) ret_pulse();
        // Wake only on a fresh flag; events set flags
        pulse(9'h010);
        cmp_val("wake count", 32'd1, w);
        pulse(9'h010);
        cmp_val("wake count", 32'd0, w);
        pulse(9'h1ff);
        rd(8'h00);
        cmp_val("token flags", 32'h71, rdat);
        rd(8'h04);
        cmp_val("group flags", 32'h77, rdat);
        rd(8'h08);
        cmp_val("timer flags", 32'hf0, rdat);
        // Grouped service leaves the timer flags to software
        wr(8'h00, 32'h0);
        serve(`VEC_MF);
        rd(8'h08);
        cmp_val("timer flags kept", 32'hf0, rdat);
        wr(8'h08, 32'h0);
        rd(8'h08);
        cmp_val("timer flags cleared", 32'h0, rdat);
        rd(8'h04);
        cmp_val("grouped flag served", 32'h67, rdat);
        wrap_up();
    end
endmodule
